// ---- shared/cpgs_map.vh ----
`ifndef CPGS_MAP_VH
`define CPGS_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CPGS_OFS_NUM        8'h00
`define CPGS_OFS_DEN        8'h04
`define CPGS_OFS_MULT       8'h08
`define CPGS_OFS_CTRL       8'h0c
`define CPGS_OFS_ACT_NUM    8'h10
`define CPGS_OFS_ACT_DEN    8'h14
`define CPGS_OFS_POS        8'h18
`define CPGS_OFS_STAT       8'h1c
// ----------------------------------------
// reset values and ranges
// ----------------------------------------
`define CPGS_NUM_RST        31'h00000020
`define CPGS_DEN_RST        31'h00000001
`define CPGS_MULT_RST       8'h01
`define CPGS_RATIO_MIN      31'h00000001
`define CPGS_RATIO_MAX      31'h40000000
`define CPGS_CTRL_RST       2'h2
// ----------------------------------------
// field positions
// ----------------------------------------
`define CPGS_CTRL_MULT_EN   0
`define CPGS_CTRL_POS_MODE  1
`define CPGS_CTRL_RESTART   2
`define CPGS_STAT_BUSY      0
`define CPGS_STAT_OVF       1
// ----------------------------------------
// sizes and counts
// ----------------------------------------
`define CPGS_DIV_STEPS      6'h28
`define CPGS_ENC_BITS       23
`define CPGS_ENC_COUNTS_REV 32'h00800000
`define CPGS_PEND_MAX       8'hff
`endif

// ---- rtl/cpgs_div.v ----
`timescale 1ns/1ps
`include "cpgs_map.vh"
module cpgs_div (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        start,
   input  wire [39:0] dividend,
   input  wire [30:0] divisor,
   output reg         done,
   output reg  [39:0] quotient,
   output reg  [30:0] remainder
);
   // ----------------------------------------
   // restoring divider, one bit per cycle
   // ----------------------------------------
   reg  [5:0]  cnt;
   reg         run;
   wire [31:0] shifted = {remainder, quotient[39]};
   wire        fits    = (shifted >= {1'b0, divisor});
   wire [31:0] diff    = shifted - {1'b0, divisor};

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt       <= 6'h00;
         run       <= 1'b0;
         done      <= 1'b0;
         quotient  <= 40'h0000000000;
         remainder <= 31'h00000000;
      end else begin
         done <= 1'b0;
         if (start) begin
            run       <= 1'b1;
            cnt       <= `CPGS_DIV_STEPS;
            quotient  <= dividend;
            remainder <= 31'h00000000;
         end else if (run) begin
            // partial remainder stays below divisor, so 31 bits suffice
            if (fits) begin
               remainder <= diff[30:0];
            end else begin
               remainder <= shifted[30:0];
            end
            quotient <= {quotient[38:0], fits};
            cnt      <= cnt - 6'h01;
            if (cnt == 6'h01) begin
               run  <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule

// ---- rtl/cpgs_top.v ----
// Operation
// - numerator setting 1..1073741824, default 32, multiplies each pulse's contribution
// - denominator setting 1..1073741824, default 1, divides the scaled contribution
// - with multiplier enabled each pulse counts as n control units
// - 23-bit encoder at unity ratio needs 8388608 counts per revolution
`timescale 1ns/1ps
`include "cpgs_map.vh"
module cpgs_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        cmd_pulse,
   input  wire        cmd_dir,
   output reg  [31:0] position_cmd,
   output reg         position_step,
   output reg  [8:0]  revolution,
   output reg         busy
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam S_IDLE  = 2'd0;
   localparam S_DIV   = 2'd1;
   localparam S_APPLY = 2'd2;

   // ----------------------------------------
   // software settings and active copies
   // ----------------------------------------
   reg  [30:0] gear_ratio_numerator;
   reg  [30:0] gear_ratio_denominator;
   reg  [7:0]  pulse_input_multiplier;
   reg         mult_en;
   reg         pos_mode;
   reg  [30:0] act_num;
   reg  [30:0] act_den;
   reg  [7:0]  act_mult;
   reg         act_mult_en;
   reg         power_up;
   reg         restart;
   reg         ovf;

   // ----------------------------------------
   // pulse input sync
   // ----------------------------------------
   reg  [1:0]  pulse_sync;
   reg  [1:0]  dir_sync;
   reg         pulse_last;
   wire        pulse_edge = pulse_sync[1] & ~pulse_last;

   // ----------------------------------------
   // pending pulses and arithmetic
   // ----------------------------------------
   reg  [7:0]  pend_fwd;
   reg  [7:0]  pend_rev;
   reg  [1:0]  state;
   reg         cur_fwd;
   reg  [30:0] rem;
   reg         div_start;
   wire        div_done;
   wire [39:0] div_q;
   wire [30:0] div_r;
   wire [7:0]  units    = act_mult_en ? act_mult : 8'h01;
   wire [30:0] base     = cur_fwd ? rem : (act_den - 31'h00000001 - rem);
   wire [39:0] scaled   = {32'h00000000, units} * {9'h000, act_num};
   wire [39:0] dividend = scaled + {9'h000, base};
   reg  [39:0] q_hold;
   wire        take_fwd = (pend_fwd != 8'h00);
   wire        take_any = take_fwd | (pend_rev != 8'h00);
   wire        accept   = pulse_edge & pos_mode;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire        setup  = psel & ~penable;
   wire        access = psel & penable & pready;
   wire        wr     = access & pwrite;
   wire        mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
   wire        wr_ok  = (pwdata >= {1'b0, `CPGS_RATIO_MIN}) && (pwdata <= {1'b0, `CPGS_RATIO_MAX});
   reg  [31:0] next_rdata;

   always @* begin
      case (paddr)
         `CPGS_OFS_NUM:     next_rdata = {1'b0, gear_ratio_numerator};
         `CPGS_OFS_DEN:     next_rdata = {1'b0, gear_ratio_denominator};
         `CPGS_OFS_MULT:    next_rdata = {24'h000000, pulse_input_multiplier};
         `CPGS_OFS_CTRL:    next_rdata = {30'h00000000, pos_mode, mult_en};
         `CPGS_OFS_ACT_NUM: next_rdata = {1'b0, act_num};
         `CPGS_OFS_ACT_DEN: next_rdata = {1'b0, act_den};
         `CPGS_OFS_POS:     next_rdata = position_cmd;
         `CPGS_OFS_STAT:    next_rdata = {8'h00, pend_rev, pend_fwd, 6'h00, ovf, busy};
         default:           next_rdata = 32'h00000000;
      endcase
   end

   // zero-wait slave: answer prepared during the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup & ~pwrite & mapped) begin
            prdata <= next_rdata;
         end else if (setup) begin
            prdata <= 32'h00000000;
         end
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gear_ratio_numerator   <= `CPGS_NUM_RST;
         gear_ratio_denominator <= `CPGS_DEN_RST;
         pulse_input_multiplier <= `CPGS_MULT_RST;
         mult_en                <= 1'b0;
         pos_mode               <= 1'b1;
         restart                <= 1'b0;
      end else begin
         // held until idle so a restart during a running step is not lost
         if (state == S_IDLE) begin
            restart <= 1'b0;
         end
         if (wr & ~pslverr) begin
            case (paddr)
               `CPGS_OFS_NUM: begin
                  // out-of-range values are dropped, old setting stays
                  if (wr_ok) gear_ratio_numerator <= pwdata[30:0];
               end
               `CPGS_OFS_DEN: begin
                  if (wr_ok) gear_ratio_denominator <= pwdata[30:0];
               end
               `CPGS_OFS_MULT: begin
                  if (pwdata[7:0] != 8'h00) pulse_input_multiplier <= pwdata[7:0];
               end
               `CPGS_OFS_CTRL: begin
                  mult_en  <= pwdata[`CPGS_CTRL_MULT_EN];
                  pos_mode <= pwdata[`CPGS_CTRL_POS_MODE];
                  restart  <= pwdata[`CPGS_CTRL_RESTART];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // power-up capture of the ratio
   // ----------------------------------------
   // restart stands in for a power cycle without losing the settings
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_up    <= 1'b1;
         act_num     <= `CPGS_NUM_RST;
         act_den     <= `CPGS_DEN_RST;
         act_mult    <= `CPGS_MULT_RST;
         act_mult_en <= 1'b0;
      end else begin
         power_up <= 1'b0;
         if ((power_up | restart) && (state == S_IDLE)) begin
            act_num     <= gear_ratio_numerator;
            act_den     <= gear_ratio_denominator;
            act_mult    <= pulse_input_multiplier;
            act_mult_en <= mult_en;
         end
      end
   end

   // ----------------------------------------
   // command pulse input
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_sync <= 2'h0;
         dir_sync   <= 2'h0;
         pulse_last <= 1'b0;
      end else begin
         pulse_sync <= {pulse_sync[0], cmd_pulse};
         dir_sync   <= {dir_sync[0], cmd_dir};
         pulse_last <= pulse_sync[1];
      end
   end

   // ----------------------------------------
   // pending pulses
   // ----------------------------------------
   // burst depth is limited; excess pulses are lost and flagged
   wire dec_fwd = (state == S_IDLE) & take_fwd & ~restart;
   wire dec_rev = (state == S_IDLE) & ~take_fwd & take_any & ~restart;
   wire ovf_clr = wr & ~pslverr & (paddr == `CPGS_OFS_STAT) & pwdata[`CPGS_STAT_OVF];
   wire add_fwd = accept & ~dir_sync[1];
   wire add_rev = accept & dir_sync[1];
   wire full_f  = (pend_fwd == `CPGS_PEND_MAX) & ~dec_fwd;
   wire full_r  = (pend_rev == `CPGS_PEND_MAX) & ~dec_rev;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_fwd <= 8'h00;
         pend_rev <= 8'h00;
         ovf      <= 1'b0;
      end else begin
         if (restart) begin
            pend_fwd <= 8'h00;
            pend_rev <= 8'h00;
         end else begin
            pend_fwd <= pend_fwd + {7'h00, add_fwd & ~full_f} - {7'h00, dec_fwd};
            pend_rev <= pend_rev + {7'h00, add_rev & ~full_r} - {7'h00, dec_rev};
         end
         // a new overflow wins over a clear in the same cycle
         if ((add_fwd & full_f) | (add_rev & full_r)) begin
            ovf <= 1'b1;
         end else if (ovf_clr) begin
            ovf <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // gear scaling sequence
   // ----------------------------------------
   // reverse steps work on the mirrored remainder so rounding stays symmetric
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= S_IDLE;
         cur_fwd       <= 1'b1;
         rem           <= 31'h00000000;
         div_start     <= 1'b0;
         q_hold        <= 40'h0000000000;
         position_cmd  <= 32'h00000000;
         position_step <= 1'b0;
         revolution    <= 9'h000;
         busy          <= 1'b0;
      end else begin
         div_start     <= 1'b0;
         position_step <= 1'b0;
         case (state)
            S_IDLE: begin
               busy <= 1'b0;
               if (restart) begin
                  rem          <= 31'h00000000;
                  position_cmd <= 32'h00000000;
                  revolution   <= 9'h000;
               end else if (take_any) begin
                  cur_fwd   <= take_fwd;
                  div_start <= 1'b1;
                  busy      <= 1'b1;
                  state     <= S_DIV;
               end
            end
            S_DIV: begin
               if (div_done) begin
                  q_hold <= div_q;
                  if (cur_fwd) begin
                     rem <= div_r;
                  end else begin
                     rem <= act_den - 31'h00000001 - div_r;
                  end
                  state <= S_APPLY;
               end
            end
            S_APPLY: begin
               if (cur_fwd) begin
                  position_cmd <= position_cmd + q_hold[31:0];
               end else begin
                  position_cmd <= position_cmd - q_hold[31:0];
               end
               position_step <= 1'b1;
               state         <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
         // follows the position every cycle, one cycle behind
         revolution <= position_cmd[31:`CPGS_ENC_BITS];
      end
   end

   // ----------------------------------------
   // divider
   // ----------------------------------------
   // dividend = units * numerator + remainder, one pulse per pass
   cpgs_div u_div (
      .clk       (pclk),
      .rst_n     (presetn),
      .start     (div_start),
      .dividend  (dividend),
      .divisor   (act_den),
      .done      (div_done),
      .quotient  (div_q),
      .remainder (div_r)
   );
endmodule

// ---- verification/cpgs_monitor.sv ----
`timescale 1ns/1ps
module cpgs_monitor (
   input wire        pclk,
   input wire        presetn,
   input wire [7:0]  paddr,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        cmd_pulse,
   input wire        cmd_dir,
   input wire [31:0] position_cmd,
   input wire        position_step,
   input wire [8:0]  revolution,
   input wire        busy
);
   // ------------------------------
   // bus and output relations
   // ------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_setup_a: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   pready_once_a: assert property (pready |=> !pready)
      else $error("pready held");
   slverr_unmapped_a: assert property (psel && !penable && (paddr >= 8'h20 || paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unmapped access not refused");
   write_rdata_a: assert property (psel && penable && pwrite && pready |-> prdata == 32'h0)
      else $error("read data on write");
   rev_track_a: assert property (revolution == $past(position_cmd[31:23]))
      else $error("revolution off position");
   step_single_a: assert property (position_step |=> !position_step)
      else $error("step longer than one cycle");
   step_busy_a: assert property (position_step |-> $past(busy))
      else $error("step without scaling");
   busy_bound_a: assert property ($rose(busy) |-> ##[20:80] position_step)
      else $error("scaling never finished");
endmodule
bind cpgs_top cpgs_monitor u_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .position_cmd(position_cmd),
   .position_step(position_step), .revolution(revolution), .busy(busy));

// ---- verification/cpgs_pulse_src.sv ----
`timescale 1ns/1ps
module cpgs_pulse_src (
   input  wire  pclk,
   output logic cmd_pulse,
   output logic cmd_dir
);
   initial begin
      cmd_pulse = 1'b0;
      cmd_dir   = 1'b0;
   end
   // gap 1 is the fastest legal rate; direction held past the last pulse
   task send(input int n, input logic dir, input int gap);
      cmd_dir <= dir;
      repeat (n) begin
         @(posedge pclk);
         cmd_pulse <= 1'b1;
         repeat (gap) @(posedge pclk);
         cmd_pulse <= 1'b0;
         repeat (gap) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
   endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "cpgs_map.vh"
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, position_cmd, rd;
   logic        pready, pslverr, cmd_pulse, cmd_dir, position_step, busy;
   logic [8:0]  revolution;
   int          fail_count, num_checks, cyc, steps;
   cpgs_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .position_cmd(position_cmd),
      .position_step(position_step), .revolution(revolution), .busy(busy));
   cpgs_pulse_src ctl (.pclk(pclk), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ------------------------------
   // helpers
   // ------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // idle cycle after release so the next call never reassigns psel in one step
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task wpos(input logic [31:0] exp);
      int n;
      n = 0;
      while ((position_cmd !== exp || busy !== 1'b0) && n < 600) begin
         @(posedge pclk);
         n++;
      end
      chk(position_cmd, exp);
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task t_reset_vals;
      rdchk(`CPGS_OFS_NUM, 32'h20);
      rdchk(`CPGS_OFS_DEN, 32'h1);
      rdchk(`CPGS_OFS_ACT_NUM, 32'h20);
      apb(1'b0, 8'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask
   task t_default_gear;
      ctl.send(3, 1'b0, 1);
      wpos(32'h60);
      ctl.send(1, 1'b1, 3);
      wpos(32'h40);
      chk(steps, 32'h4);
   endtask
   task t_power_cycle;
      // 3/2 sits inside the allowed quotient range
      apb(1'b1, `CPGS_OFS_NUM, 32'h3);
      apb(1'b1, `CPGS_OFS_DEN, 32'h2);
      ctl.send(1, 1'b0, 2);
      wpos(32'h60);
      rdchk(`CPGS_OFS_ACT_NUM, 32'h20);
      apb(1'b1, `CPGS_OFS_CTRL, 32'h6);
      rdchk(`CPGS_OFS_ACT_NUM, 32'h3);
      rdchk(`CPGS_OFS_ACT_DEN, 32'h2);
      rdchk(`CPGS_OFS_POS, 32'h0);
      ctl.send(3, 1'b0, 1);
      wpos(32'h4);
      ctl.send(3, 1'b1, 1);
      wpos(32'h0);
   endtask
   task t_limits;
      apb(1'b1, `CPGS_OFS_NUM, 32'h0);
      rdchk(`CPGS_OFS_NUM, 32'h3);
      apb(1'b1, `CPGS_OFS_NUM, 32'h40000001);
      rdchk(`CPGS_OFS_NUM, 32'h3);
      apb(1'b1, `CPGS_OFS_DEN, 32'h40000000);
      rdchk(`CPGS_OFS_DEN, 32'h40000000);
      apb(1'b1, `CPGS_OFS_DEN, 32'h2);
   endtask
   task t_mult;
      apb(1'b1, `CPGS_OFS_MULT, 32'h4);
      apb(1'b1, `CPGS_OFS_CTRL, 32'h7);
      ctl.send(1, 1'b0, 2);
      wpos(32'h6);
      apb(1'b1, `CPGS_OFS_CTRL, 32'h6);
      ctl.send(1, 1'b0, 2);
      wpos(32'h1);
   endtask
   task t_mode_off;
      apb(1'b1, `CPGS_OFS_CTRL, 32'h4);
      ctl.send(2, 1'b0, 1);
      wpos(32'h0);
      apb(1'b1, `CPGS_OFS_CTRL, 32'h6);
   endtask
   task t_rev;
      apb(1'b1, `CPGS_OFS_NUM, `CPGS_ENC_COUNTS_REV);
      apb(1'b1, `CPGS_OFS_DEN, 32'h1);
      apb(1'b1, `CPGS_OFS_CTRL, 32'h6);
      ctl.send(1, 1'b0, 2);
      wpos(`CPGS_ENC_COUNTS_REV);
      @(posedge pclk);
      chk({23'h0, revolution}, 32'h1);
      // stepping back across a revolution boundary must bring revolution back to 0
      ctl.send(1, 1'b1, 2);
      wpos(32'h0);
      @(posedge pclk);
      chk({23'h0, revolution}, 32'h0);
      // controller scales itself: drive left at 1:1, one count per pulse
      apb(1'b1, `CPGS_OFS_NUM, 32'h1);
      apb(1'b1, `CPGS_OFS_CTRL, 32'h6);
      ctl.send(2, 1'b0, 1);
      wpos(32'h2);
   endtask
   // ------------------------------
   // run control
   // ------------------------------
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      if (position_step === 1'b1) begin
         steps++;
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         $display("[ERR] %0t run timed out", $time);
         finish_test;
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset_vals;
      t_default_gear;
      t_power_cycle;
      t_limits;
      t_mult;
      t_mode_off;
      t_rev;
      finish_test;
   end
endmodule
